// ### logic/ibt_pkg.sv
package ibt_pkg;

  // ------------------------------------------------------------
  // Widths and depths
  // ------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int BRG_W      = 7;
  localparam int PHASE_W    = 8;

  // ------------------------------------------------------------
  // Bit positions within one byte frame
  // ------------------------------------------------------------
  localparam logic [3:0] FIRST_BIT     = 4'h0;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT       = 4'h8;
  localparam int         MSB_POS       = 7;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [7:0]       SHIFT_RST = 8'h00;
  localparam logic [3:0]       BITS_RST  = 4'h0;
  localparam logic [BRG_W-1:0] BRG_RST   = 7'h00;
  localparam logic [7:0]       PHASE_RST = 8'h00;

  // ------------------------------------------------------------
  // Shifter states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH_WAIT,
    ST_HIGH
  } ibt_state_t;

endpackage

// ### logic/ibt_stream_if.sv
`timescale 1ns/1ns
interface ibt_stream_if #(
  parameter int WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (
    output valid,
    output data,
    input  ready
  );

  modport snk (
    input  valid,
    input  data,
    output ready
  );
endinterface

// ### logic/ibt_fifo.sv
`timescale 1ns/1ns
module ibt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  ibt_stream_if.src             out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != FULL_CNT);
  assign out.valid = (count != '0);
  assign out.data  = mem[rd_ptr];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out.valid && out.ready;
  assign next_count = push && !pop ? count + 1'b1 :
                      pop && !push ? count - 1'b1 : count;

  // Storage has no reset; a slot is only popped at rd_ptr after a push has written it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
    end
  end
endmodule

// ### logic/ibt_brg.sv
`timescale 1ns/1ns
module ibt_brg (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic                      run,
  input  wire logic [ibt_pkg::BRG_W-1:0] reload,
  output      logic                      tick
);
  logic [ibt_pkg::BRG_W-1:0] count;

  // Rollover every reload+1 enabled cycles; stopping reloads at once
  assign tick = run && (count == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= ibt_pkg::BRG_RST;
    end else if (ce) begin
      if (!run || count == '0) begin
        count <= reload;
      end else begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ### logic/ibt_master_tx.sv
`timescale 1ns/1ns
module ibt_master_tx (
  input  wire logic                       MCLK,
  input  wire logic                       RST_N,
  input  wire logic                       CE,
  input  wire logic                       TX_WR,
  input  wire logic [ibt_pkg::DATA_W-1:0] TX_DATA,
  output      logic                       TX_READY,
  input  wire logic                       IRQ_CLR,
  input  wire logic                       WRITE_COLLISION_FLAG_CLR,
  input  wire logic [ibt_pkg::BRG_W-1:0]  BRG_RELOAD,
  input  wire logic                       SCL_I,
  output      logic                       SCL_O,
  output      logic                       SCL_OE_N,
  input  wire logic                       SDA_I,
  output      logic                       SDA_O,
  output      logic                       SDA_OE_N,
  output      logic                       BUFFER_FULL_FLAG,
  output      logic                       ACK_STATUS_BIT,
  output      logic                       SERIAL_IRQ_FLAG,
  output      logic                       WRITE_COLLISION_FLAG
);

  // ------------------------------------------------------------
  // State and datapath registers
  // ------------------------------------------------------------
  ibt_pkg::ibt_state_t              state;
  ibt_pkg::ibt_state_t              next_state;
  logic [ibt_pkg::DATA_W-1:0]       tx_shift_buffer;
  logic [3:0]                       bit_cnt;
  logic                             sda_pend;
  logic [ibt_pkg::PHASE_W-1:0]      phase_cnt;

  // ------------------------------------------------------------
  // Decoded conditions
  // ------------------------------------------------------------
  logic                             tick;
  logic                             fifo_in_ready;
  logic                             shifting;
  logic                             drain_ok;
  logic                             load;
  logic                             wr_ok;
  logic                             wr_bad;
  logic                             low_done;
  logic                             high_done;
  logic                             scl_seen;
  logic                             last_bit;
  logic                             brg_run;
  logic                             sda_bit;
  logic                             put_bit;

  ibt_stream_if #(.WIDTH(ibt_pkg::DATA_W)) queue ();

  assign shifting  = (state != ibt_pkg::ST_IDLE);
  assign last_bit  = (bit_cnt == ibt_pkg::ACK_BIT);
  // Held bytes wait until software has seen the previous completion
  assign drain_ok  = !shifting && !SERIAL_IRQ_FLAG;
  assign queue.ready = drain_ok;
  assign load      = CE && queue.valid && drain_ok;
  assign wr_ok     = TX_WR && !shifting && fifo_in_ready;
  assign wr_bad    = TX_WR && !wr_ok;
  assign low_done  = (state == ibt_pkg::ST_LOW) && tick;
  assign high_done = (state == ibt_pkg::ST_HIGH) && tick;
  assign scl_seen  = (state == ibt_pkg::ST_HIGH_WAIT) && SCL_I;
  assign brg_run   = (state == ibt_pkg::ST_LOW) || (state == ibt_pkg::ST_HIGH);
  // Ninth bit leaves SDA released for the slave's answer
  assign sda_bit   = last_bit ? 1'b1 : tx_shift_buffer[ibt_pkg::MSB_POS];
  assign put_bit   = (state == ibt_pkg::ST_LOW) && sda_pend;

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  ibt_fifo #(
    .WIDTH(ibt_pkg::DATA_W),
    .DEPTH(ibt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .ce       (CE),
    .in_valid (wr_ok),
    .in_ready (fifo_in_ready),
    .in_data  (TX_DATA),
    .out      (queue.src)
  );

  // Reload 0 leaves SDA no setup before SCL rises; use 1 or more
  ibt_brg u_brg (
    .clk    (MCLK),
    .rst_n  (RST_N),
    .ce     (CE),
    .run    (brg_run),
    .reload (BRG_RELOAD),
    .tick   (tick)
  );

  // ------------------------------------------------------------
  // Bit sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ibt_pkg::ST_IDLE: begin
        if (load) begin
          next_state = ibt_pkg::ST_LOW;
        end
      end
      ibt_pkg::ST_LOW: begin
        if (low_done) begin
          next_state = ibt_pkg::ST_HIGH_WAIT;
        end
      end
      ibt_pkg::ST_HIGH_WAIT: begin
        // Slave may stretch; high time counts from the seen rise
        if (scl_seen) begin
          next_state = ibt_pkg::ST_HIGH;
        end
      end
      ibt_pkg::ST_HIGH: begin
        if (high_done) begin
          next_state = last_bit ? ibt_pkg::ST_IDLE : ibt_pkg::ST_LOW;
        end
      end
      default: begin
        next_state = ibt_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ibt_pkg::ST_IDLE;
    end else if (CE) begin
      state <= next_state;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_shift_buffer <= ibt_pkg::SHIFT_RST;
    end else if (CE && load) begin
      tx_shift_buffer <= queue.data;
    end else if (CE && high_done && !last_bit) begin
      tx_shift_buffer <= {tx_shift_buffer[6:0], 1'b0};
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      bit_cnt <= ibt_pkg::BITS_RST;
    end else if (CE && load) begin
      bit_cnt <= ibt_pkg::FIRST_BIT;
    end else if (CE && high_done) begin
      bit_cnt <= last_bit ? ibt_pkg::FIRST_BIT : bit_cnt + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      SCL_OE_N <= 1'b1;
    end else if (CE && (load || high_done)) begin
      SCL_OE_N <= 1'b0;
    end else if (CE && low_done) begin
      SCL_OE_N <= 1'b1;
    end
  end

  // SDA moves one cycle after the fall, giving slaves hold time
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sda_pend <= 1'b0;
    end else if (CE && (load || high_done)) begin
      sda_pend <= 1'b1;
    end else if (CE && put_bit) begin
      sda_pend <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      SDA_OE_N <= 1'b1;
    end else if (CE && put_bit) begin
      SDA_OE_N <= sda_bit;
    end
  end

  // Open drain: the driven level is always low
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      SCL_O <= 1'b0;
      SDA_O <= 1'b0;
    end else begin
      SCL_O <= 1'b0;
      SDA_O <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      BUFFER_FULL_FLAG <= 1'b0;
    end else if (CE && load) begin
      BUFFER_FULL_FLAG <= 1'b1;
    end else if (CE && high_done && bit_cnt == ibt_pkg::LAST_DATA_BIT) begin
      BUFFER_FULL_FLAG <= 1'b0;
    end
  end

  // Sampled at the seen rise of the ninth clock
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ACK_STATUS_BIT <= 1'b0;
    end else if (CE && scl_seen && last_bit) begin
      ACK_STATUS_BIT <= SDA_I;
    end
  end

  // Set beats a clear arriving in the same cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      SERIAL_IRQ_FLAG <= 1'b0;
    end else if (CE && high_done && last_bit) begin
      SERIAL_IRQ_FLAG <= 1'b1;
    end else if (CE && IRQ_CLR) begin
      SERIAL_IRQ_FLAG <= 1'b0;
    end
  end

  // Collision stays until software clears it; later bytes still go out while it is set
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      WRITE_COLLISION_FLAG <= 1'b0;
    end else if (CE && wr_bad) begin
      WRITE_COLLISION_FLAG <= 1'b1;
    end else if (CE && WRITE_COLLISION_FLAG_CLR) begin
      WRITE_COLLISION_FLAG <= 1'b0;
    end
  end

  // One cycle late; a write on a stale high is refused as a collision
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_READY <= 1'b0;
    end else if (CE) begin
      TX_READY <= fifo_in_ready && !shifting;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Enabled cycles spent in the current state
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_cnt <= ibt_pkg::PHASE_RST;
    end else if (CE) begin
      phase_cnt <= (state != next_state) ? ibt_pkg::PHASE_RST : phase_cnt + 1'b1;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  launch_full_a: assert property (load |=> BUFFER_FULL_FLAG && !SCL_OE_N)
    else $error("load did not set full flag and pull SCL low");

  launch_state_a: assert property (load |=> state == ibt_pkg::ST_LOW)
    else $error("load did not start a byte");

  low_time_a: assert property (CE && low_done |-> phase_cnt == {1'b0, BRG_RELOAD})
    else $error("SCL low time differs from one baud period");

  high_time_a: assert property (CE && high_done |-> phase_cnt == {1'b0, BRG_RELOAD})
    else $error("SCL high time differs from one baud period");

  sda_steady_a: assert property (
    state inside {ibt_pkg::ST_HIGH_WAIT, ibt_pkg::ST_HIGH} |-> $stable(SDA_OE_N))
    else $error("SDA moved while SCL released");

  sda_after_fall_a: assert property ($fell(SCL_OE_N) |-> $stable(SDA_OE_N))
    else $error("SDA moved together with SCL fall");

  scl_release_a: assert property (CE && low_done |=> SCL_OE_N)
    else $error("SCL not released after low phase");

  eighth_fall_a: assert property (
    CE && high_done && bit_cnt == ibt_pkg::LAST_DATA_BIT |=> !BUFFER_FULL_FLAG ##1 SDA_OE_N)
    else $error("eighth fall did not clear full flag and free SDA");

  ack_capture_a: assert property (
    CE && scl_seen && last_bit |=> ACK_STATUS_BIT == $past(SDA_I))
    else $error("acknowledge level not captured");

  byte_end_a: assert property (
    CE && high_done && last_bit
    |=> SERIAL_IRQ_FLAG && !SCL_OE_N && SDA_OE_N && state == ibt_pkg::ST_IDLE)
    else $error("byte end did not flag and stall");

  frame_end_a: assert property (
    CE && high_done && last_bit |=> !BUFFER_FULL_FLAG && !brg_run)
    else $error("frame end left full flag or baud counter running");

  stall_hold_a: assert property (SERIAL_IRQ_FLAG |-> !load)
    else $error("byte started before completion was cleared");

  idle_hold_a: assert property (
    state == ibt_pkg::ST_IDLE && !load |=> $stable(SCL_OE_N) && $stable(SDA_OE_N))
    else $error("lines moved while stalled");

  // Discard is checked at the queue; the shifter may move on the same edge
  collision_a: assert property (
    CE && TX_WR && shifting |=> WRITE_COLLISION_FLAG && $stable(u_fifo.count))
    else $error("write while shifting not flagged");

  low_only_a: assert property (!SCL_O && !SDA_O)
    else $error("pin driven high");

  // ------------------------------------------------------------
  // Coverage
  // ------------------------------------------------------------
  byte_cov: cover property (CE && high_done && last_bit);
  nack_cov: cover property (CE && scl_seen && last_bit && SDA_I);
  write_collision_flag_cov: cover property (CE && wr_bad && shifting);
  full_cov: cover property (!fifo_in_ready);
  stretch_cov: cover property (state == ibt_pkg::ST_HIGH_WAIT && !SCL_I);

endmodule

// ### test/ibt_slave_model.sv
`timescale 1ns/1ns
module ibt_slave_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_en,
  input  wire logic [3:0] stretch,
  output      logic       scl_oe_n,
  output      logic       sda_oe_n,
  output      logic [7:0] rx_byte,
  output      logic [7:0] rx_cnt
);
  // ------------------------------------------------------------
  // Receiver of one frame: eight bits, then the acknowledge
  // ------------------------------------------------------------
  logic       scl_q;
  logic [3:0] bits;
  logic [6:0] sh;
  logic [3:0] hold;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q    <= 1'b1;
      bits     <= 4'h0;
      sh       <= 7'h00;
      hold     <= 4'h0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      rx_byte  <= 8'h00;
      rx_cnt   <= 8'h00;
    end else begin
      scl_q <= scl;
      if (scl && !scl_q) begin
        bits <= bits + 4'h1;
        sh   <= {sh[5:0], sda};
        // Byte ready before the master can flag its end
        if (bits == 4'h7) begin
          rx_byte <= {sh, sda};
          rx_cnt  <= rx_cnt + 8'h01;
        end
      end
      if (!scl && scl_q) begin
        if (bits == 4'h8) begin
          sda_oe_n <= !ack_en;
        end
        if (bits == 4'h9) begin
          sda_oe_n <= 1'b1;
          bits     <= 4'h0;
        end
        // Stretch the low phase beyond the master's own count
        hold     <= stretch;
        scl_oe_n <= (stretch == 4'h0);
      end else if (hold != 4'h0) begin
        hold     <= hold - 4'h1;
        scl_oe_n <= (hold == 4'h1);
      end
    end
  end
endmodule

// ### test/tb.sv
`timescale 1ns/1ns
module tb;
  // ------------------------------------------------------------
  // Stimulus, wires and bookkeeping
  // ------------------------------------------------------------
  logic       MCLK, RST_N, CE, TX_WR, IRQ_CLR, WRITE_COLLISION_FLAG_CLR, ack_en;
  logic [7:0] tx_data, rx_byte, rx_cnt, cnt0;
  logic [6:0] brg;
  logic [3:0] stretch;
  logic       scl_o, scl_oe_n, sda_o, sda_oe_n, s_scl_oe_n, s_sda_oe_n;
  logic       tx_ready, bf, ack, irq, write_collision_flag, bf_seen, fall;
  logic       scl_oe_q, scl_seen_q, sda_oe_q, bf_q, lo_arm, hi_arm;
  int         miscompares = 0;
  int         n_tests = 0;
  int         cycles = 0;
  int         low_n, high_n, falls;
  // Open-drain lines with pull-ups
  wire        scl_w = (scl_oe_n ? 1'b1 : scl_o) & s_scl_oe_n;
  wire        sda_w = (sda_oe_n ? 1'b1 : sda_o) & s_sda_oe_n;
  wire [7:0]  p = {1'b0, brg} + 8'h01;

  ibt_master_tx dut (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .TX_WR(TX_WR), .TX_DATA(tx_data),
    .TX_READY(tx_ready), .IRQ_CLR(IRQ_CLR), .WRITE_COLLISION_FLAG_CLR(WRITE_COLLISION_FLAG_CLR), .BRG_RELOAD(brg),
    .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_N(scl_oe_n), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE_N(sda_oe_n), .BUFFER_FULL_FLAG(bf), .ACK_STATUS_BIT(ack),
    .SERIAL_IRQ_FLAG(irq), .WRITE_COLLISION_FLAG(write_collision_flag));
  ibt_slave_model slave (.clk(MCLK), .rst_n(RST_N), .scl(scl_w), .sda(sda_w),
    .ack_en(ack_en), .stretch(stretch), .scl_oe_n(s_scl_oe_n), .sda_oe_n(s_sda_oe_n),
    .rx_byte(rx_byte), .rx_cnt(rx_cnt));

  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic put(input logic [7:0] d);
    @(posedge MCLK);
    #1 TX_WR = 1'b1;
    tx_data = d;
    @(posedge MCLK);
    #1 TX_WR = 1'b0;
  endtask

  task automatic clr_irq;
    @(posedge MCLK);
    #1 IRQ_CLR = 1'b1;
    @(posedge MCLK);
    #1 IRQ_CLR = 1'b0;
  endtask

  task automatic finish(input logic [7:0] d, input logic nak, input logic clr);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge MCLK);
      #1 n = n + 1;
    end
    check(8'(irq), 8'h01);
    check(rx_byte, d);
    check(8'(ack), 8'(nak));
    check(8'(bf_seen), 8'h01);
    check({6'h00, scl_oe_n, sda_oe_n}, 8'h01);
    bf_seen = 1'b0;
    if (clr) clr_irq();
  endtask

  // ------------------------------------------------------------
  // Line monitor: phase lengths, SDA stability, flag timing
  // ------------------------------------------------------------
  always @(posedge MCLK) begin
    if (!RST_N) begin
      {scl_oe_q, scl_seen_q, sda_oe_q, bf_q, lo_arm, hi_arm} = 6'b111000;
      low_n = 0;
      high_n = 0;
      falls = 0;
      bf_seen = 1'b0;
    end else begin
      check(8'(scl_o | sda_o), 8'h00);
      if (bf === 1'b1) bf_seen = 1'b1;
      if (scl_seen_q) check(8'(sda_oe_n), 8'(sda_oe_q));
      fall = scl_oe_q && !scl_oe_n;
      if (fall) begin
        falls = falls + 1;
        if (hi_arm) check(8'(high_n >= p && high_n <= p + 1), 8'h01);
        // The stall after a frame is not a timed low phase
        lo_arm = (irq !== 1'b1);
        hi_arm = 1'b0;
        low_n = 0;
      end
      if (bf && !bf_q) falls = 0;
      if (fall && falls > 0 && falls < 8) check(8'(bf), 8'h01);
      if (fall && falls == 8) check(8'(bf), 8'h00);
      if (fall && falls == 9) check({6'h00, irq, sda_oe_n}, 8'h03);
      if (!scl_oe_n && CE) low_n = low_n + 1;
      if (lo_arm && scl_oe_n) begin
        check(8'(low_n), p);
        lo_arm = 1'b0;
      end
      if (!scl_seen_q && scl_w) begin
        hi_arm = 1'b1;
        high_n = 0;
      end
      if (scl_w && CE) high_n = high_n + 1;
      {scl_oe_q, scl_seen_q, sda_oe_q, bf_q} = {scl_oe_n, scl_w, sda_oe_n, bf};
    end
  end

  // Ceiling well above the few thousand cycles the tests need
  always @(posedge MCLK) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    {RST_N, CE, TX_WR, IRQ_CLR, WRITE_COLLISION_FLAG_CLR, ack_en} = 6'b010001;
    // Reload 1 is the shortest phase that still gives SDA setup time
    {tx_data, brg, stretch} = {8'h00, 7'h01, 4'h0};
    repeat (2) @(posedge MCLK);
    check({2'b00, scl_oe_n, sda_oe_n, bf, ack, irq, write_collision_flag}, 8'h30);
    #1 RST_N = 1'b1;
    put(8'hA5);
    finish(8'hA5, 1'b0, 1'b1);
    brg = 7'h03;
    ack_en = 1'b0;
    put(8'h3C);
    finish(8'h3C, 1'b1, 1'b1);
    ack_en = 1'b1;
    put(8'hC3);
    repeat (12) @(posedge MCLK);
    #1 CE = 1'b0;
    repeat (10) @(posedge MCLK);
    #1 CE = 1'b1;
    finish(8'hC3, 1'b0, 1'b1);
    cnt0 = rx_cnt;
    put(8'h5A);
    repeat (3) @(posedge MCLK);
    put(8'hFF);
    check(8'(write_collision_flag), 8'h01);
    finish(8'h5A, 1'b0, 1'b0);
    check(rx_cnt, cnt0 + 8'h01);
    @(posedge MCLK);
    #1 WRITE_COLLISION_FLAG_CLR = 1'b1;
    @(posedge MCLK);
    #1 WRITE_COLLISION_FLAG_CLR = 1'b0;
    check(8'(write_collision_flag), 8'h00);
    // Flag still up: sixteen writes queue, the seventeenth is refused
    for (int i = 0; i < 16; i++) put(8'h80 + 8'(i));
    @(posedge MCLK);
    #1 check(8'(tx_ready), 8'h00);
    put(8'hEE);
    check(8'(write_collision_flag), 8'h01);
    stretch = 4'h8;
    clr_irq();
    for (int i = 0; i < 16; i++) finish(8'h80 + 8'(i), 1'b0, 1'b1);
    repeat (3) @(posedge MCLK);
    #1 check(8'(tx_ready), 8'h01);
    check(rx_cnt, cnt0 + 8'h11);
    conclude();
  end
endmodule
